// ===== acps_pin_mux.v
// Clock output and shared address pin multiplexer with Wishbone registers
//
// The implementer's own choices: the Wishbone slave port and the register addresses.
`timescale 1ns/1ps
// Operation
// - Clock output pin drives clock picked by source select register.
// - Address pins carry external memory address lines 0 to 15.
// - Idle bus: address and control pins tri-state unless drive-keep bit set.
// - After reset every shared pin takes its address function.
// - Shared pin in port mode has per-pin programmable direction.
// - Per-pin pull-up on by default; on lines 0 to 7 clearing its bit turns it off.
// - Address lines 0 to 5 are port A bits 8 to 13.
// - Address lines 6 and 7 are port E bits 2 and 3.
`include "acps_regs.vh"
module acps_pin_mux #(
  parameter ADDR_W = 16,
  parameter CTL_W = 4
) (
  input wire clk_i,
  input wire rst_i,
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_we_i,
  input wire [7:0] wb_adr_i,
  input wire [3:0] wb_sel_i,
  input wire [31:0] wb_dat_i,
  output reg [31:0] wb_dat_o,
  output reg wb_ack_o,
  output wire wb_err_o,
  input wire system_master_clock_i,
  input wire peripheral_bus_clock_i,
  input wire osc_clock_i,
  input wire prescaler_clock_i,
  input wire postscaler_clock_i,
  input wire [ADDR_W-1:0] emi_addr_i,
  input wire [CTL_W-1:0] emi_ctl_i,
  input wire emi_active_i,
  output wire clock_out_pin_o,
  output wire clock_out_pin_oe_o,
  input wire [ADDR_W-1:0] addr_pin_i,
  output wire [ADDR_W-1:0] addr_pin_o,
  output wire [ADDR_W-1:0] addr_pin_oe_o,
  output wire [ADDR_W-1:0] addr_pin_pu_o,
  output wire [CTL_W-1:0] emi_ctl_pin_o,
  output wire [CTL_W-1:0] emi_ctl_pin_oe_o
);
  // ***************************************
  // Register state
  // ***************************************
  reg [`ACPS_CLKSEL_W-1:0] clock_out_source_select_q;
  reg bus_drive_keep_q;
  reg [15:0] pa_per_q;
  reg [15:0] pa_ddr_q;
  reg [15:0] port_a_pullup_enable_q;
  reg [15:0] pa_dout_q;
  reg [15:0] pe_per_q;
  reg [15:0] pe_ddr_q;
  reg [15:0] port_e_pullup_enable_q;
  reg [15:0] pe_dout_q;
  reg [ADDR_W-1:0] pin_in_q;
  reg [31:0] rd_d;
  reg hit_d;
  wire req = wb_cyc_i & wb_stb_i;
  wire [`ACPS_IDX_W-1:0] idx = wb_adr_i[`ACPS_IDX_HI:`ACPS_IDX_LO];
  wire wr = req & wb_we_i & ~wb_ack_o & hit_d;
  // Byte lane merge for a 16-bit register in the low half
  function [15:0] merge16;
    input [15:0] old;
    input [31:0] dat;
    input [3:0] sel;
    begin
      merge16 = old;
      if (sel[0])
      begin
        merge16[7:0] = dat[7:0];
      end
      if (sel[1])
      begin
        merge16[15:8] = dat[15:8];
      end
    end
  endfunction
  // ***************************************
  // Read decode
  // ***************************************
  always @*
  begin
    rd_d = 32'h0000_0000;
    hit_d = 1'b1;
    case (idx)
      `ACPS_IDX_CLKSEL: rd_d[`ACPS_CLKSEL_W-1:0] = clock_out_source_select_q;
      `ACPS_IDX_BUSCTL: rd_d[`ACPS_DRV_BIT] = bus_drive_keep_q;
      `ACPS_IDX_PA_PER: rd_d[15:0] = pa_per_q;
      `ACPS_IDX_PA_DDR: rd_d[15:0] = pa_ddr_q;
      `ACPS_IDX_PA_PUR: rd_d[15:0] = port_a_pullup_enable_q;
      `ACPS_IDX_PE_PER: rd_d[15:0] = pe_per_q;
      `ACPS_IDX_PE_DDR: rd_d[15:0] = pe_ddr_q;
      `ACPS_IDX_PE_PUR: rd_d[15:0] = port_e_pullup_enable_q;
      `ACPS_IDX_PA_DOUT: rd_d[15:0] = pa_dout_q;
      `ACPS_IDX_PE_DOUT: rd_d[15:0] = pe_dout_q;
      `ACPS_IDX_PA_DIN: rd_d[ADDR_W-1:0] = pin_in_q;
      `ACPS_IDX_PE_DIN: rd_d[ADDR_W-1:0] = pin_in_q;
      `ACPS_IDX_STATUS: rd_d[`ACPS_ACT_BIT] = emi_active_i;
      default: hit_d = 1'b0;
    endcase
  end
  // ***************************************
  // Bus answer
  // ***************************************
  // Unmapped offsets answer with err instead of ack
  reg err_q;
  reg ack_d;
  reg err_d;
  reg [31:0] dat_d;
  assign wb_err_o = err_q;
  // One answer per request; a strobe held through the answer cycle is not taken again
  always @*
  begin
    ack_d = 1'b0;
    err_d = 1'b0;
    dat_d = 32'h0000_0000;
    if (req & ~wb_ack_o & ~err_q)
    begin
      ack_d = hit_d;
      err_d = ~hit_d;
    end
    // Writes return zero so stale read data never shows on the bus
    if (req & ~wb_we_i & hit_d)
    begin
      dat_d = rd_d;
    end
  end
  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      wb_ack_o <= 1'b0;
      err_q <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
      pin_in_q <= {ADDR_W{1'b0}};
    end
    else
    begin
      wb_ack_o <= ack_d;
      err_q <= err_d;
      wb_dat_o <= dat_d;
      pin_in_q <= addr_pin_i;
    end
  end
  // ***************************************
  // Clock and bus control registers
  // ***************************************
  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      clock_out_source_select_q <= `ACPS_CLKSEL_RST;
      bus_drive_keep_q <= `ACPS_DRV_RST;
    end
    else if (wr)
    begin
      case (idx)
        `ACPS_IDX_CLKSEL:
        begin
          if (wb_sel_i[0])
          begin
            clock_out_source_select_q <= wb_dat_i[`ACPS_CLKSEL_W-1:0];
          end
        end
        `ACPS_IDX_BUSCTL:
        begin
          if (wb_sel_i[0])
          begin
            bus_drive_keep_q <= wb_dat_i[`ACPS_DRV_BIT];
          end
        end
        default:
        begin
        end
      endcase
    end
  end
  // ***************************************
  // Port A registers
  // ***************************************
  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      pa_per_q <= `ACPS_PER_RST;
      pa_ddr_q <= `ACPS_DDR_RST;
      port_a_pullup_enable_q <= `ACPS_PUR_RST;
      pa_dout_q <= `ACPS_DOUT_RST;
    end
    else if (wr)
    begin
      case (idx)
        `ACPS_IDX_PA_PER: pa_per_q <= merge16(pa_per_q, wb_dat_i, wb_sel_i);
        `ACPS_IDX_PA_DDR: pa_ddr_q <= merge16(pa_ddr_q, wb_dat_i, wb_sel_i);
        `ACPS_IDX_PA_PUR:
          port_a_pullup_enable_q <= merge16(port_a_pullup_enable_q, wb_dat_i, wb_sel_i);
        `ACPS_IDX_PA_DOUT: pa_dout_q <= merge16(pa_dout_q, wb_dat_i, wb_sel_i);
        default:
        begin
        end
      endcase
    end
  end
  // ***************************************
  // Port E registers
  // ***************************************
  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      pe_per_q <= `ACPS_PER_RST;
      pe_ddr_q <= `ACPS_DDR_RST;
      port_e_pullup_enable_q <= `ACPS_PUR_RST;
      pe_dout_q <= `ACPS_DOUT_RST;
    end
    else if (wr)
    begin
      case (idx)
        `ACPS_IDX_PE_PER: pe_per_q <= merge16(pe_per_q, wb_dat_i, wb_sel_i);
        `ACPS_IDX_PE_DDR: pe_ddr_q <= merge16(pe_ddr_q, wb_dat_i, wb_sel_i);
        `ACPS_IDX_PE_PUR:
          port_e_pullup_enable_q <= merge16(port_e_pullup_enable_q, wb_dat_i, wb_sel_i);
        `ACPS_IDX_PE_DOUT: pe_dout_q <= merge16(pe_dout_q, wb_dat_i, wb_sel_i);
        default:
        begin
        end
      endcase
    end
  end
  // ***************************************
  // Clock output
  // ***************************************
  reg clk_mux_d;
  always @*
  begin
    case (clock_out_source_select_q)
      `ACPS_SRC_MSTR: clk_mux_d = system_master_clock_i;
      `ACPS_SRC_PBUS: clk_mux_d = peripheral_bus_clock_i;
      `ACPS_SRC_OSC: clk_mux_d = osc_clock_i;
      `ACPS_SRC_PRE: clk_mux_d = prescaler_clock_i;
      `ACPS_SRC_POST: clk_mux_d = postscaler_clock_i;
      default: clk_mux_d = 1'b0;
    endcase
  end
  // Combinational mux: switching sources may glitch, software should disable first
  wire clk_en = (clock_out_source_select_q != `ACPS_SRC_OFF) &&
                (clock_out_source_select_q <= `ACPS_SRC_POST);
  assign clock_out_pin_oe_o = clk_en & ~rst_i;
  assign clock_out_pin_o = clk_mux_d & clock_out_pin_oe_o;
  // ***************************************
  // Shared address pins
  // ***************************************
  // Drive while active or drive-keep
  wire bus_drive = (emi_active_i | bus_drive_keep_q) & ~rst_i;
  assign emi_ctl_pin_o = emi_ctl_i;
  assign emi_ctl_pin_oe_o = {CTL_W{bus_drive}};
  // Lines below PA_N ride on port A, the next PE_N on port E
  localparam PA_N = `ACPS_PA_HI - `ACPS_PA_LO + 1;
  localparam PE_N = `ACPS_PE_HI - `ACPS_PE_LO + 1;
  genvar g;
  generate
    for (g = 0; g < ADDR_W; g = g + 1)
    begin : g_pin
      wire gpio_sel;
      wire gpio_dir;
      wire gpio_out;
      wire pull_en;
      if (g < PA_N)
      begin : g_pa
        assign gpio_sel = pa_per_q[g + `ACPS_PA_LO];
        assign gpio_dir = pa_ddr_q[g + `ACPS_PA_LO];
        assign gpio_out = pa_dout_q[g + `ACPS_PA_LO];
        assign pull_en = port_a_pullup_enable_q[g + `ACPS_PA_LO];
      end
      else if (g < PA_N + PE_N)
      begin : g_pe
        assign gpio_sel = pe_per_q[g - PA_N + `ACPS_PE_LO];
        assign gpio_dir = pe_ddr_q[g - PA_N + `ACPS_PE_LO];
        assign gpio_out = pe_dout_q[g - PA_N + `ACPS_PE_LO];
        assign pull_en = port_e_pullup_enable_q[g - PA_N + `ACPS_PE_LO];
      end
      else
      begin : g_fix
        // Upper lines have no port mapping here; address only, pull-up fixed on
        assign gpio_sel = 1'b0;
        assign gpio_dir = 1'b0;
        assign gpio_out = 1'b0;
        assign pull_en = 1'b1;
      end
      assign addr_pin_o[g] = gpio_sel ? gpio_out : emi_addr_i[g];
      assign addr_pin_oe_o[g] = ~rst_i & (gpio_sel ? gpio_dir : bus_drive);
      assign addr_pin_pu_o[g] = rst_i | pull_en;
    end
  endgenerate
endmodule

// ===== acps_regs.vh
// Register map and field constants for the address and clock pin sharing block
`ifndef ACPS_REGS_VH
`define ACPS_REGS_VH
// ***************************************
// Register byte offsets
// ***************************************
`define ACPS_OFF_CLKSEL 4'h0
`define ACPS_OFF_BUSCTL 4'h4
`define ACPS_OFF_PA_PER 4'h8
`define ACPS_OFF_PA_DDR 4'hc
`define ACPS_IDX_W 4
// Word index slice of the byte address
`define ACPS_IDX_HI 5
`define ACPS_IDX_LO 2
`define ACPS_IDX_CLKSEL 4'h0
`define ACPS_IDX_BUSCTL 4'h1
`define ACPS_IDX_PA_PER 4'h2
`define ACPS_IDX_PA_DDR 4'h3
`define ACPS_IDX_PA_PUR 4'h4
`define ACPS_IDX_PE_PER 4'h5
`define ACPS_IDX_PE_DDR 4'h6
`define ACPS_IDX_PE_PUR 4'h7
`define ACPS_IDX_PA_DOUT 4'h8
`define ACPS_IDX_PE_DOUT 4'h9
`define ACPS_IDX_PA_DIN 4'ha
`define ACPS_IDX_PE_DIN 4'hb
`define ACPS_IDX_STATUS 4'hc
// ***************************************
// Fields and reset values
// ***************************************
`define ACPS_CLKSEL_W 3
`define ACPS_SRC_OFF 3'h0
`define ACPS_SRC_MSTR 3'h1
`define ACPS_SRC_PBUS 3'h2
`define ACPS_SRC_OSC 3'h3
`define ACPS_SRC_PRE 3'h4
`define ACPS_SRC_POST 3'h5
`define ACPS_CLKSEL_RST 3'h0
`define ACPS_DRV_BIT 0
`define ACPS_DRV_RST 1'h0
`define ACPS_ACT_BIT 0
`define ACPS_PA_LO 8
`define ACPS_PA_HI 13
`define ACPS_PE_LO 2
`define ACPS_PE_HI 3
`define ACPS_PER_RST 16'h0000
`define ACPS_DDR_RST 16'h0000
`define ACPS_PUR_RST 16'hffff
`define ACPS_DOUT_RST 16'h0000
`endif

// ===== acps_pin_mux_chk.sv
// Port-level checker for the clock and address pin multiplexer
`timescale 1ns/1ps
module acps_pin_mux_chk #(
  parameter ADDR_W = 16,
  parameter CTL_W = 4
) (
  input wire clk_i,
  input wire rst_i,
  input wire wb_ack_o,
  input wire system_master_clock_i,
  input wire peripheral_bus_clock_i,
  input wire osc_clock_i,
  input wire prescaler_clock_i,
  input wire postscaler_clock_i,
  input wire [ADDR_W-1:0] emi_addr_i,
  input wire [CTL_W-1:0] emi_ctl_i,
  input wire emi_active_i,
  input wire clock_out_pin_o,
  input wire clock_out_pin_oe_o,
  input wire [ADDR_W-1:0] addr_pin_o,
  input wire [ADDR_W-1:0] addr_pin_oe_o,
  input wire [ADDR_W-1:0] addr_pin_pu_o,
  input wire [CTL_W-1:0] emi_ctl_pin_o,
  input wire [CTL_W-1:0] emi_ctl_pin_oe_o
);
  wire any_src = system_master_clock_i | peripheral_bus_clock_i | osc_clock_i
    | prescaler_clock_i | postscaler_clock_i;
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  a_clk_src: assert property (clock_out_pin_o |-> clock_out_pin_oe_o && any_src)
    else $error("clock pin high with no enabled source");
  a_high_addr: assert property (addr_pin_o[15:8] == emi_addr_i[15:8])
    else $error("upper address pins differ from bus address");
  a_active_drive: assert property (emi_active_i |-> &emi_ctl_pin_oe_o && &addr_pin_oe_o[15:8])
    else $error("active bus not driven");
  a_idle_float: assert property (!emi_ctl_pin_oe_o[0] |-> !emi_active_i && !addr_pin_oe_o[15:8])
    else $error("idle address pins driven while control floats");
  a_ctl_pass: assert property (emi_ctl_pin_o == emi_ctl_i)
    else $error("control pins differ from bus strobes");
  a_reset_safe: assert property ($fell(rst_i) |-> !$past(clock_out_pin_oe_o)
    && $past(addr_pin_oe_o) == '0 && &$past(addr_pin_pu_o)) else $error("pins driven in reset");
  a_reset_addr: assert property ($fell(rst_i) |-> addr_pin_o == emi_addr_i
    && addr_pin_oe_o == {ADDR_W{emi_active_i}}) else $error("pins not in address mode");
  a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("acknowledge longer than one cycle");
endmodule
bind acps_pin_mux acps_pin_mux_chk #(.ADDR_W(ADDR_W), .CTL_W(CTL_W)) u_chk (.clk_i, .rst_i,
  .wb_ack_o, .system_master_clock_i, .peripheral_bus_clock_i, .osc_clock_i, .prescaler_clock_i,
  .postscaler_clock_i, .emi_addr_i, .emi_ctl_i, .emi_active_i, .clock_out_pin_o,
  .clock_out_pin_oe_o, .addr_pin_o, .addr_pin_oe_o, .addr_pin_pu_o, .emi_ctl_pin_o,
  .emi_ctl_pin_oe_o);

// ===== acps_board_model.sv
// Board model resolving the shared address pads
`timescale 1ns/1ps
module acps_board_model (
  input wire clk_i,
  input wire [15:0] pin_o_i,
  input wire [15:0] pin_oe_i,
  input wire [15:0] pin_pu_i,
  output wire [15:0] pad_o
);
  reg [15:0] last_q = 16'h0000;
  // Released pad without pull-up reads the inverse of its last driven level, never a stale copy
  always @(posedge clk_i)
    last_q <= (pin_oe_i & pin_o_i) | (~pin_oe_i & last_q);
  assign pad_o = (pin_oe_i & pin_o_i) | (~pin_oe_i & (pin_pu_i | ~last_q));
endmodule

// ===== address_clock_pin_sharing_tb_top.sv
// Self-checking bench for the clock and address pin multiplexer
`timescale 1ns/1ps
module address_clock_pin_sharing_tb_top;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic emi_act = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [31:0] wdat = 32'h0;
  logic [31:0] seed = 32'h2595;
  logic [4:0] src = 5'h00;
  logic [15:0] emi_addr = 16'h0000;
  logic [3:0] emi_ctl = 4'h0;
  logic [15:0] pad, pin_o, pin_oe, pin_pu;
  logic [31:0] rdat;
  logic ack, err, clk_o, clk_oe;
  logic [32:0] q[$];
  int fails = 0;
  int n_tests = 0;
  acps_pin_mux dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(4'h3), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
    .wb_err_o(err), .system_master_clock_i(src[0]), .peripheral_bus_clock_i(src[1]),
    .osc_clock_i(src[2]), .prescaler_clock_i(src[3]), .postscaler_clock_i(src[4]),
    .emi_addr_i(emi_addr), .emi_ctl_i(emi_ctl), .emi_active_i(emi_act),
    .clock_out_pin_o(clk_o), .clock_out_pin_oe_o(clk_oe), .addr_pin_i(pad), .addr_pin_o(pin_o),
    .addr_pin_oe_o(pin_oe), .addr_pin_pu_o(pin_pu), .emi_ctl_pin_o(), .emi_ctl_pin_oe_o());
  acps_board_model board (.clk_i(clk_i), .pin_o_i(pin_o), .pin_oe_i(pin_oe),
    .pin_pu_i(pin_pu), .pad_o(pad));
  initial
    forever
      #20 clk_i = ~clk_i;
  task complete_run();
    $display("Comparisons %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task check(input logic [32:0] s, input logic [32:0] e);
    n_tests++;
    if (s !== e)
    begin
      fails++;
      $display("wrong value at %0t: seen %h expected %h", $time, s, e);
    end
  endtask
  function automatic logic [31:0] xorshift(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction
  task stir();
    seed = xorshift(seed);
    src <= seed[4:0];
    emi_ctl <= seed[8:5];
    emi_addr <= seed[31:16];
  endtask
  // Note the expected answer, then hold the request until it is answered
  task wb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [32:0] e);
    q.push_back(e);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    do @(posedge clk_i); while (ack !== 1'b1 && err !== 1'b1);
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clk_i);
  endtask
  always @(posedge clk_i)
    if (ack === 1'b1 || err === 1'b1)
      check({err, rdat}, q.pop_front());
  initial
  begin
    repeat (2000) @(posedge clk_i);
    fails++;
    complete_run();
  end
  initial
  begin
    repeat (10) @(posedge clk_i);
    check({clk_oe, pin_oe, pin_pu}, {17'h0, 16'hffff});
    stir();
    rst_i <= 1'b0;
    repeat (2) @(posedge clk_i);
    check({pin_o, pin_oe, 1'b0}, {emi_addr, 17'h0});
    for (int i = 0; i < 10; i++)
      wb(1'b0, 8'(i * 4), 32'h0, {17'h0, (i == 4 || i == 7) ? 16'hffff : 16'h0000});
    wb(1'b0, 8'h34, 32'h0, {1'b1, 32'h0});
    for (int i = 0; i < 8; i++)
    begin
      wb(1'b1, 8'h00, 32'(i), 33'h0);
      stir();
      repeat (2) @(posedge clk_i);
      check({clk_oe, clk_o}, (i > 0 && i < 6) ? {31'h0, 1'b1, src[i-1]} : 33'h0);
    end
    // Keep the idle bus driven
    wb(1'b1, 8'h04, 32'h1, 33'h0);
    check({17'h0, pin_oe}, {17'h0, 16'hffff});
    wb(1'b1, 8'h08, 32'h3f00, 33'h0);
    wb(1'b1, 8'h0c, 32'h0500, 33'h0);
    wb(1'b1, 8'h20, 32'h2100, 33'h0);
    wb(1'b1, 8'h10, 32'hfeff, 33'h0);
    wb(1'b1, 8'h14, 32'h000c, 33'h0);
    wb(1'b1, 8'h18, 32'h0008, 33'h0);
    wb(1'b1, 8'h1c, 32'hfffb, 33'h0);
    check({1'b0, pin_oe, pin_pu}, {1'b0, 16'hff85, 16'hffbe});
    check({30'h0, pin_o[7], pin_o[2], pin_o[0]}, 33'h1);
    // Pad readback: driven lines, pulled-up inputs, released line A6 inverted
    wb(1'b0, 8'h28, 32'h0, {17'h0, emi_addr[15:8], 1'b0, ~emi_addr[6], 6'h3b});
    wb(1'b0, 8'h10, 32'h0, {17'h0, 16'hfeff});
    wb(1'b1, 8'h3c, 32'hffff, {1'b1, 32'h0});
    emi_act <= 1'b1;
    repeat (2) @(posedge clk_i);
    wb(1'b0, 8'h30, 32'h0, 33'h1);
    emi_act <= 1'b0;
    // Second reset with a live clock source and cleared pull-ups
    wb(1'b1, 8'h00, 32'h1, 33'h0);
    check({32'h0, clk_oe}, 33'h1);
    rst_i <= 1'b1;
    @(posedge clk_i);
    check({clk_oe, pin_oe, pin_pu}, {17'h0, 16'hffff});
    @(posedge clk_i);
    rst_i <= 1'b0;
    repeat (2) @(posedge clk_i);
    check({clk_oe, pin_oe, pin_pu}, {17'h0, 16'hffff});
    wb(1'b0, 8'h1c, 32'h0, {17'h0, 16'hffff});
    complete_run();
  end
endmodule
